// [core/power_budget_acs_cap_regs.v]
// Power budgeting and access-control capability registers behind APB.
//
// Operation
// RQ1: Power header reads identifier 0004h and version 1h, read-only.
// RQ2: Power header next pointer is 230h upstream, 220h downstream.
// RQ3: Eight-bit index, reset 00h; 00h D0 maximum, 01h D0 sustained.
// RQ4: Any other index returns an all-zero power record.
// RQ5: Base power bits 7:0 reset 04h watts, may come from EEPROM.
// RQ6: Scale, substate and state fields read zero.
// RQ7: Type field reads 111b, power rail field reads 010b.
// RQ8: System allocated flag in bit 0 resets 0b, EEPROM may set it.
// RQ9: Downstream only: access header 000Dh, version 1h, next 000h.
// RQ10: Access capability bits 0 to 6 read one each.
// RQ11: Egress vector size field in bits 15:8 reads 08h.
// RQ12: Enables in bits 16 to 22 are read-write and reset zero.
// RQ13: Egress blocking vector bits 7:0, read-write, reset 00h.
// RQ14: Reserved bits read zero and ignore writes.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module power_budget_acs_cap_regs #(
    parameter IS_UPSTREAM = 0
) (
    // Clock and reset.
    input wire ref_clk,
    input wire rstn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // EEPROM autoload values.
    input wire load_valid,
    input wire [7:0] load_base_power,
    input wire load_alloc,
    // Access-control state toward the routing logic.
    output reg [6:0] acs_enable,
    output reg [7:0] egress_block
);
`include "pwr_acs_map.vh"
    ////////////////////////////////////////////////////////////////////////
    // Field widths of the writable registers.
    localparam SEL_W = 8;
    localparam EGR_W = 8;
    localparam ACS_W = 7;

    ////////////////////////////////////////////////////////////////////////
    // Writable and autoloaded state.
    reg [SEL_W-1:0] record_sel;
    reg [SEL_W-1:0] next_record_sel;
    reg [7:0] base_power;
    reg [7:0] next_base_power;
    reg alloc_flag;
    reg next_alloc_flag;
    wire [EGR_W-1:0] next_egress_block;
    wire [ACS_W-1:0] next_acs_enable;
    wire [31:0] record_word;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and response.
    reg [31:0] rd;
    reg hit;
    reg next_pready;
    reg next_pslverr;
    reg [31:0] next_prdata;
    wire setup_phase;
    wire access_phase;
    wire wr_commit;
    wire sel_wr;
    wire egress_wr;
    wire acs_wr;
    wire ds;
    wire [11:0] pb_next;
    wire sel_hit;
    wire egress_hit;
    wire acs_hit;

    ////////////////////////////////////////////////////////////////////////
    // A write commits at the edge where pready is seen high.
    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable & pready;
    assign wr_commit = access_phase & pwrite & hit;
    assign sel_hit = (paddr == `OFS_PB_SEL);
    assign egress_hit = (paddr == `OFS_EGRESS);
    assign acs_hit = (paddr == `OFS_AC_CTL);
    assign sel_wr = wr_commit & sel_hit & pstrb[0]; // [RQ3]
    assign egress_wr = wr_commit & egress_hit & pstrb[0]; // [RQ13]
    assign acs_wr = wr_commit & acs_hit & pstrb[2]; // [RQ12]

    ////////////////////////////////////////////////////////////////////////
    // Port role decides the pointer and the presence of access control.
    assign ds = (IS_UPSTREAM == 0);
    assign pb_next = ds ? `PB_NEXT_DN : `PB_NEXT_UP; // [RQ2]

    ////////////////////////////////////////////////////////////////////////
    // Power record lookup.
    pwr_record_mux u_mux (
        .record_sel(record_sel),
        .base_power(base_power),
        .record_word(record_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Power budgeting header.
    wire [31:0] pb_hdr_word;
    assign pb_hdr_word[15:0] = `PB_CAP_ID; // [RQ1]
    assign pb_hdr_word[19:16] = `CAP_VER; // [RQ1]
    assign pb_hdr_word[31:20] = pb_next; // [RQ2]

    ////////////////////////////////////////////////////////////////////////
    // Record index word.
    wire [31:0] pb_sel_word;
    assign pb_sel_word[SEL_W-1:0] = record_sel; // [RQ3]
    assign pb_sel_word[31:SEL_W] = 24'h000000; // [RQ14]

    ////////////////////////////////////////////////////////////////////////
    // Power record word.
    wire [31:0] pb_data_word;
    assign pb_data_word = record_word; // [RQ4]

    ////////////////////////////////////////////////////////////////////////
    // System allocation word.
    wire [31:0] pb_alloc_word;
    assign pb_alloc_word[0] = alloc_flag; // [RQ8]
    assign pb_alloc_word[31:1] = 31'h00000000; // [RQ14]

    ////////////////////////////////////////////////////////////////////////
    // Access-control header.
    wire [31:0] ac_hdr_word;
    assign ac_hdr_word[15:0] = `AC_CAP_ID; // [RQ9]
    assign ac_hdr_word[19:16] = `CAP_VER; // [RQ9]
    assign ac_hdr_word[31:20] = `AC_NEXT; // [RQ9]

    ////////////////////////////////////////////////////////////////////////
    // Access-control capability and control word.
    wire [31:0] ac_ctl_word;
    assign ac_ctl_word[6:0] = `AC_CAPS; // [RQ10]
    assign ac_ctl_word[7] = 1'b0; // [RQ14]
    assign ac_ctl_word[15:8] = `EGRESS_SIZE; // [RQ11]
    assign ac_ctl_word[22:16] = acs_enable; // [RQ12]
    assign ac_ctl_word[31:23] = 9'h000; // [RQ14]

    ////////////////////////////////////////////////////////////////////////
    // Egress blocking word.
    wire [31:0] egress_word;
    assign egress_word[EGR_W-1:0] = egress_block; // [RQ13]
    assign egress_word[31:EGR_W] = 24'h000000; // [RQ14]

    ////////////////////////////////////////////////////////////////////////
    // Address table; the top three entries exist on downstream ports only.
    localparam NUM_REGS = 7;
    localparam [NUM_REGS*12-1:0] REG_OFS = {
        `OFS_EGRESS,
        `OFS_AC_CTL,
        `OFS_AC_HDR,
        `OFS_PB_ALLOC,
        `OFS_PB_DATA,
        `OFS_PB_SEL,
        `OFS_PB_HDR
    };
    localparam [NUM_REGS-1:0] DS_ONLY = 7'h70;
    wire [NUM_REGS*32-1:0] reg_words;
    wire [NUM_REGS-1:0] reg_live;
    wire [NUM_REGS*32-1:0] rd_chain;
    assign reg_words = {
        egress_word,
        ac_ctl_word,
        ac_hdr_word,
        pb_alloc_word,
        pb_data_word,
        pb_sel_word,
        pb_hdr_word
    };

    ////////////////////////////////////////////////////////////////////////
    // Each entry matches its offset; the read word is an AND-OR chain.
    genvar ri;
    generate
        for (ri = 0; ri < NUM_REGS; ri = ri + 1) begin : g_decode
            assign reg_live[ri] = (paddr == REG_OFS[ri*12 +: 12]) &
                (ds | ~DS_ONLY[ri]); // [RQ9]
            if (ri == 0) begin : g_first
                assign rd_chain[31:0] = reg_words[31:0] &
                    {32{reg_live[0]}};
            end else begin : g_next
                assign rd_chain[ri*32 +: 32] = rd_chain[(ri-1)*32 +: 32] |
                    (reg_words[ri*32 +: 32] & {32{reg_live[ri]}});
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Final read word and the mapped-address flag.
    always @* begin
        rd = rd_chain[NUM_REGS*32-1 -: 32];
        hit = |reg_live; // [RQ14]
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer: one answer cycle follows every setup cycle.
    localparam ST_IDLE = 1'b0;
    localparam ST_ANSWER = 1'b1;
    reg state;
    reg next_state;

    ////////////////////////////////////////////////////////////////////////
    // Next response and sequencer state.
    always @* begin
        next_state = state;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        case (state)
            ST_IDLE: begin
                if (setup_phase) begin
                    next_state = ST_ANSWER;
                    next_pready = 1'b1;
                    next_pslverr = ~hit; // [RQ14]
                    if (pwrite) begin
                        next_prdata = 32'h0000_0000;
                    end else begin
                        next_prdata = rd;
                    end
                end
            end
            ST_ANSWER: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Record index; only the low byte lane carries it.
    always @* begin
        next_record_sel = record_sel;
        if (sel_wr) begin
            next_record_sel = pwdata[SEL_W-1:0]; // [RQ3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-bit next value of the egress vector.
    genvar gi;
    generate
        for (gi = 0; gi < EGR_W; gi = gi + 1) begin : g_egress
            assign next_egress_block[gi] = egress_wr ?
                pwdata[gi] : egress_block[gi]; // [RQ13]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Per-bit next value of the access-control enables.
    genvar ei;
    generate
        for (ei = 0; ei < ACS_W; ei = ei + 1) begin : g_enable
            assign next_acs_enable[ei] = acs_wr ?
                pwdata[`AC_EN_LSB+ei] : acs_enable[ei]; // [RQ12]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Autoload values replace the power defaults.
    always @* begin
        next_base_power = base_power;
        next_alloc_flag = alloc_flag;
        if (load_valid) begin
            next_base_power = load_base_power; // [RQ5]
            next_alloc_flag = load_alloc; // [RQ8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus response registers.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state <= next_state;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Record index register.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            record_sel <= `SEL_RESET; // [RQ3]
        end else begin
            record_sel <= next_record_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Egress blocking register.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            egress_block <= `EGRESS_RESET; // [RQ13]
        end else begin
            egress_block <= next_egress_block;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access-control enable register.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            acs_enable <= `AC_EN_RESET; // [RQ12]
        end else begin
            acs_enable <= next_acs_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Autoloaded base power.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            base_power <= `BASE_PWR_RESET; // [RQ5]
        end else begin
            base_power <= next_base_power;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Autoloaded system allocation flag.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            alloc_flag <= `ALLOC_RESET; // [RQ8]
        end else begin
            alloc_flag <= next_alloc_flag;
        end
    end
endmodule

// [core/pwr_acs_map.vh]
// Register offsets, field positions and reset values of the capability block.
`ifndef PWR_ACS_MAP_VH
`define PWR_ACS_MAP_VH
`define OFS_PB_HDR 12'h20C
`define OFS_PB_SEL 12'h210
`define OFS_PB_DATA 12'h214
`define OFS_PB_ALLOC 12'h218
`define OFS_AC_HDR 12'h220
`define OFS_AC_CTL 12'h224
`define OFS_EGRESS 12'h228
`define PB_CAP_ID 16'h0004
`define CAP_VER 4'h1
`define PB_NEXT_UP 12'h230
`define PB_NEXT_DN 12'h220
`define AC_CAP_ID 16'h000D
`define AC_NEXT 12'h000
`define SEL_D0_MAX 8'h00
`define SEL_D0_SUST 8'h01
`define SEL_RESET 8'h00
`define BASE_PWR_RESET 8'h04
`define DATA_SCALE_RESET 2'h0
`define SUBSTATE_RESET 3'h0
`define STATE_RESET 2'h0
`define TYPE_RESET 3'h7
`define RAIL_RESET 3'h2
`define ALLOC_RESET 1'h0
`define AC_CAPS 7'h7F
`define EGRESS_SIZE 8'h08
`define AC_EN_RESET 7'h00
`define EGRESS_RESET 8'h00
`define AC_EN_LSB 16
`define AC_SIZE_LSB 8
`endif

// [core/pwr_record_mux.v]
// Power record lookup selected by the software index.
`timescale 1ns/1ps
module pwr_record_mux (
    // Index and record fields.
    input wire [7:0] record_sel,
    input wire [7:0] base_power,
    // Assembled data word.
    output reg [31:0] record_word
);
`include "pwr_acs_map.vh"
    always @* begin
        record_word = 32'h0000_0000;
        if (record_sel == `SEL_D0_MAX || record_sel == `SEL_D0_SUST) begin // [RQ3]
            record_word = {11'h000, `RAIL_RESET, `TYPE_RESET, `STATE_RESET,
                `SUBSTATE_RESET, `DATA_SCALE_RESET, base_power}; // [RQ5] [RQ6] [RQ7]
        end
        // Any other index keeps the zero word. [RQ4]
    end
endmodule

// [bench/pbac_props.sv]
// Concurrent checks of the capability registers.
`timescale 1ns/1ps
module pbac_props (input wire logic ref_clk, rstn, psel, penable, pwrite,
    pready, pslverr, input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata, input wire logic [3:0] pstrb,
    input wire logic [6:0] acs_enable, input wire logic [7:0] egress_block);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire su = psel && !penable;
    wire wr = psel && penable && pready && pwrite;
    wire rd = pready && !pwrite;
    AST_RDY: assert property (su |=> pready ##1 !pready)
        else $error("ready late");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("stray error");
    AST_PBH: assert property (rd && paddr == 12'h20C |->
        prdata == 32'h2201_0004) else $error("power header");
    AST_ACH: assert property (rd && paddr == 12'h220 |->
        prdata == 32'h0001_000D) else $error("access header");
    AST_PBD: assert property (rd && paddr == 12'h214 |->
        prdata[31:21] == 0 && (prdata[20:8] == 13'h0B80 || prdata == 0))
        else $error("power data");
    AST_ALC: assert property (rd && paddr == 12'h218 |->
        prdata[31:1] == 0) else $error("alloc");
    AST_CAP: assert property (rd && paddr == 12'h224 |->
        prdata[15:0] == 16'h087F && prdata[31:23] == 0) else $error("caps");
    AST_EGR: assert property (wr && paddr == 12'h228 && pstrb[0] |=>
        {24'h0, egress_block} == ($past(pwdata) & 32'hFF)) else $error("egr");
    AST_ENA: assert property (wr && paddr == 12'h224 && pstrb[2] |=>
        {acs_enable, 16'h0} == ($past(pwdata) & 32'h7F_0000))
        else $error("enables");
    cover property (pslverr);
    cover property (egress_block == 8'hA5);
    cover property (rd && paddr == 12'h214 && prdata[7:0] == 8'h2A);
endmodule
bind power_budget_acs_cap_regs pbac_props u_props (.*);

// [bench/tb_top.sv]
// Directed testbench of the capability registers.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
    logic load_valid, load_alloc;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] load_base_power, egress_block;
    logic [6:0] acs_enable;
    int err_count = 0;
    int tests_run = 0;
    power_budget_acs_cap_regs uut (.*);
    initial begin ref_clk = 0; forever #25 ref_clk = ~ref_clk; end
    task chk(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk) penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
        @(posedge ref_clk);
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0); chk(rd, e);
    endtask
    task close_out;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task t_reset;
        rchk(12'h20C, 32'h2201_0004);
        rchk(12'h210, 32'h0);
        rchk(12'h214, 32'h000B_8004);
        rchk(12'h218, 32'h0);
        rchk(12'h220, 32'h0001_000D);
        rchk(12'h224, 32'h0000_087F);
        rchk(12'h228, 32'h0);
    endtask
    task t_sel;
        apb(1, 12'h210, 32'hFFFF_FF01);
        rchk(12'h210, 32'h1);
        rchk(12'h214, 32'h000B_8004);
        apb(1, 12'h210, 32'h2);
        rchk(12'h214, 32'h0);
    endtask
    task t_acs;
        apb(1, 12'h224, 32'hFFFF_FFFF);
        rchk(12'h224, 32'h007F_087F);
        chk(acs_enable, 32'h7F);
        apb(1, 12'h228, 32'hFFFF_FFA5);
        rchk(12'h228, 32'hA5);
        chk(egress_block, 32'hA5);
        apb(1, 12'h20C, 32'h0);
        rchk(12'h20C, 32'h2201_0004);
        apb(0, 12'h300, 0);
        chk(er, 1);
    endtask
    task t_load;
        load_base_power <= 8'h2A; load_alloc <= 1; load_valid <= 1;
        @(posedge ref_clk) load_valid <= 0;
        apb(1, 12'h210, 32'h0);
        rchk(12'h214, 32'h000B_802A);
        rchk(12'h218, 32'h1);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rstn} = 0;
        {load_valid, load_alloc, load_base_power} = 0;
        pstrb = 4'hF;
        repeat (2) @(posedge ref_clk);
        rstn <= 1;
        @(posedge ref_clk);
        t_reset; t_sel; t_acs; t_load; close_out;
    end
    initial begin #50000; err_count++; close_out; end
endmodule
